// File: design/psw_ctrl.sv
// Power switch, wake event and chassis intrusion control.
// Assumes switch, wake and command inputs are synchronous, active high levels.
`timescale 1ns/1ns
module psw_ctrl #(
	parameter int unsigned PRESS_THR = psw_pkg::PRESS_THR_CYC
) (
	// Clock, reset, enable
	input  wire logic               core_clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	// Front panel and chassis
	input  wire logic               pwr_sw_i,
	input  wire logic               intrusion_sw_i,
	input  wire logic               intrusion_clr_i,
	// Wake sources and options
	input  wire psw_pkg::psw_wake_s wake_i,
	input  wire logic               s5_lan_pme_en_i,
	// OS commands
	input  wire psw_pkg::psw_os_cmd_s os_cmd_i,
	// Status and power control
	output logic [4:0]              state_o,
	output logic                    dev_pwr_en_o,
	output logic                    wake_logic_pwr_o,
	output logic                    cold_boot_o,
	output logic                    intrusion_o
);

	localparam int unsigned CW = psw_pkg::PRESS_CNT_W;

	psw_pkg::psw_state_e state_ff;
	psw_pkg::psw_state_e nxt_state;
	logic [CW-1:0]       press_cnt_ff;
	logic                sw_prev_ff;
	logic                long_done_ff;
	logic                dev_pwr_ff;
	logic                cold_boot_ff;
	logic                intrusion_ff;
	logic                wake_pwr_ff;
	logic                long_evt;
	logic                short_evt;
	logic                sleeping;
	logic                wake_ok;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// Press timing
	// ----------------------------------------------------------------
	// Long fires once, while still held, the cycle the hold reaches the threshold
	assign long_evt  = pwr_sw_i && !long_done_ff &&
		(press_cnt_ff == CW'(PRESS_THR - 1));
	// Short fires on release, unless the press already counted as long
	assign short_evt = !pwr_sw_i && sw_prev_ff && !long_done_ff;

	// Counter saturates after a long press, so a stuck switch cannot retrigger
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			press_cnt_ff <= '0;
			sw_prev_ff   <= 1'b0;
			long_done_ff <= 1'b0;
		end else if (ce_i) begin
			sw_prev_ff <= pwr_sw_i;
			if (!pwr_sw_i) begin
				press_cnt_ff <= '0;
				long_done_ff <= 1'b0;
			end else if (long_evt) begin
				long_done_ff <= 1'b1;
			end else if (!long_done_ff) begin
				press_cnt_ff <= press_cnt_ff + CW'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Wake qualification per sleep state
	// ----------------------------------------------------------------
	assign sleeping = (state_ff != psw_pkg::PSW_S0);

	always_comb begin
		wake_ok = wake_i.rtc || wake_i.pcie_wake;
		case (state_ff)
			psw_pkg::PSW_S1,
			psw_pkg::PSW_S3: begin
				wake_ok = wake_ok || wake_i.lan || wake_i.pme ||
					wake_i.modem || wake_i.ps2 || wake_i.usb;
			end
			psw_pkg::PSW_S4: begin
				wake_ok = wake_ok || wake_i.lan || wake_i.pme;
			end
			psw_pkg::PSW_S5: begin
				wake_ok = wake_ok ||
					(s5_lan_pme_en_i && (wake_i.lan || wake_i.pme));
			end
			default: begin
				wake_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State selection: long press, then short press, then wake, then OS
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		if (long_evt) begin
			nxt_state = psw_pkg::PSW_S5;
		end else if (short_evt) begin
			case (state_ff)
				psw_pkg::PSW_S0: nxt_state = psw_pkg::SW_SLEEP;
				default:         nxt_state = psw_pkg::PSW_S0;
			endcase
		end else if (sleeping && wake_ok) begin
			nxt_state = psw_pkg::PSW_S0;
		end else if (os_cmd_i.valid && !sleeping) begin
			// Only legal one-hot sleep targets are obeyed; others are dropped
			case (os_cmd_i.target)
				psw_pkg::PSW_S1,
				psw_pkg::PSW_S3,
				psw_pkg::PSW_S4,
				psw_pkg::PSW_S5: nxt_state = os_cmd_i.target;
				default:         nxt_state = state_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State and power outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_ff     <= psw_pkg::STATE_RST;
			dev_pwr_ff   <= 1'b0;
			cold_boot_ff <= 1'b0;
			wake_pwr_ff  <= 1'b1;
		end else if (ce_i) begin
			state_ff     <= nxt_state;
			// Power tracks the next state so the output never lags the state
			dev_pwr_ff   <= (nxt_state == psw_pkg::PSW_S0) ||
				(nxt_state == psw_pkg::PSW_S1);
			wake_pwr_ff  <= 1'b1;
			cold_boot_ff <= (state_ff == psw_pkg::PSW_S5) &&
				(nxt_state == psw_pkg::PSW_S0);
		end
	end

	// ----------------------------------------------------------------
	// Chassis intrusion, sticky until cleared; a new closure beats the clear
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			intrusion_ff <= 1'b0;
		end else if (ce_i) begin
			if (intrusion_sw_i) begin
				intrusion_ff <= 1'b1;
			end else if (intrusion_clr_i) begin
				intrusion_ff <= 1'b0;
			end
		end
	end

	assign state_o          = state_ff;
	assign dev_pwr_en_o     = dev_pwr_ff;
	assign wake_logic_pwr_o = wake_pwr_ff;
	assign cold_boot_o      = cold_boot_ff;
	assign intrusion_o      = intrusion_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_SHORT_OFF_ON: assert property (
		ce_i && short_evt && state_ff == psw_pkg::PSW_S5 |=> state_o == 5'h01)
		else $error("Short press from soft-off did not power on");
	AST_SHORT_SLEEP: assert property (
		ce_i && short_evt && state_ff == psw_pkg::PSW_S0 |=> state_o == 5'h04)
		else $error("Short press while working did not sleep");
	AST_LONG_WORK_OFF: assert property (
		ce_i && state_ff == psw_pkg::PSW_S0 && pwr_sw_i && !long_done_ff
		&& press_cnt_ff == CW'(PRESS_THR - 1) |=> state_o == 5'h10 && !dev_pwr_en_o)
		else $error("Long press while working did not force soft-off");
	AST_SHORT_WAKE: assert property (
		ce_i && short_evt && state_ff inside {psw_pkg::PSW_S1, psw_pkg::PSW_S3,
		psw_pkg::PSW_S4} |=> state_o == 5'h01 && dev_pwr_en_o)
		else $error("Short press while sleeping did not wake");
	AST_LONG_SLEEP_OFF: assert property (
		ce_i && long_evt && sleeping |=> state_o == 5'h10 && !dev_pwr_en_o)
		else $error("Long press while sleeping did not go to soft-off");
	AST_S5_LAN_MASKED: assert property (
		ce_i && state_ff == psw_pkg::PSW_S5 && !s5_lan_pme_en_i && !pwr_sw_i
		&& !sw_prev_ff && !wake_i.rtc && !wake_i.pcie_wake |=> state_o == 5'h10)
		else $error("Soft-off left without a permitted wake source");
	AST_S4_SLOW_IGNORED: assert property (
		ce_i && state_ff == psw_pkg::PSW_S4 && !pwr_sw_i && !sw_prev_ff
		&& !wake_i.rtc && !wake_i.pcie_wake && !wake_i.lan && !wake_i.pme
		|=> state_o == 5'h08)
		else $error("S4 left on a source that may not wake it");
	AST_ANY_WAKE: assert property (
		ce_i && sleeping && (wake_i.rtc || wake_i.pcie_wake) && !long_evt
		|=> state_o == 5'h01)
		else $error("RTC or bus wake did not wake the system");
	AST_COLD_BOOT: assert property (
		ce_i && state_ff == psw_pkg::PSW_S5 ##1 state_ff == psw_pkg::PSW_S0
		|-> cold_boot_o ##1 (!$past(ce_i) || !cold_boot_o))
		else $error("Cold boot not flagged for one cycle on leaving soft-off");
	AST_DEEP_POWER: assert property (
		state_ff inside {psw_pkg::PSW_S3, psw_pkg::PSW_S4, psw_pkg::PSW_S5}
		|-> !dev_pwr_en_o && wake_logic_pwr_o)
		else $error("Device power present in a deep sleep state");
	AST_INTRUSION: assert property (
		ce_i && intrusion_sw_i |=> intrusion_o)
		else $error("Closed intrusion switch not reported");
	// Sticky: only an explicit clear may drop the flag
	AST_INTRUSION_HOLD: assert property (
		ce_i && intrusion_o && !intrusion_clr_i |=> intrusion_o)
		else $error("Chassis intrusion flag dropped without a clear");
	AST_OS_CMD: assert property (
		ce_i && os_cmd_i.valid && os_cmd_i.target == psw_pkg::PSW_S4 && !sleeping
		&& !pwr_sw_i && !sw_prev_ff |=> state_o == 5'h08)
		else $error("OS sleep command not obeyed");

	COV_POWER_ON:  cover property (ce_i && short_evt && state_ff == psw_pkg::PSW_S5);
	COV_FAIL_SAFE: cover property (ce_i && long_evt && state_ff == psw_pkg::PSW_S0);
	COV_LAN_S5:    cover property (ce_i && state_ff == psw_pkg::PSW_S5 && wake_ok
		&& wake_i.lan);
	COV_INTRUSION: cover property (intrusion_o && intrusion_clr_i);

endmodule // psw_ctrl

// File: design/psw_pkg.sv
// Constants, states and carriers for the power switch and wake controller.
// Assumes a single 20 MHz clock domain; all inputs already synchronous.
package psw_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned PRESS_THR_S   = 4;            // Press threshold in seconds
	localparam int unsigned PRESS_THR_CYC = PRESS_THR_S * CLK_HZ;
	localparam int unsigned PRESS_CNT_W   = 27;

	// ----------------------------------------------------------------
	// System states (one-hot)
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		PSW_S0 = 5'h01,   // Working
		PSW_S1 = 5'h02,   // Processor stopped
		PSW_S3 = 5'h04,   // Suspend to RAM
		PSW_S4 = 5'h08,   // Suspend to disk
		PSW_S5 = 5'h10    // Soft off
	} psw_state_e;

	// Reset state and short-press sleep target
	localparam psw_state_e STATE_RST = PSW_S5;
	localparam psw_state_e SW_SLEEP  = PSW_S3;   // Target of a short press while working

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic lan;
		logic pme;
		logic modem;
		logic ps2;
		logic usb;
		logic rtc;
		logic pcie_wake;
	} psw_wake_s;

	typedef struct packed {
		logic       valid;
		psw_state_e target;
	} psw_os_cmd_s;

endpackage

// File: dv/psw_ctrl_tb.sv
// Self-checking bench for the power switch and wake controller.
// Assumes a 20 MHz clock; press threshold shortened to keep runs brief.
`timescale 1ns/1ns
module psw_ctrl_tb;
	localparam int unsigned THR = 8;       // Press threshold in cycles
	logic                 core_clk_i = 1'b0;
	logic                 rst_i      = 1'b1;
	logic                 ce_i       = 1'b1;
	logic                 intr_sw    = 1'b0;
	logic                 intr_clr   = 1'b0;
	logic                 s5_en      = 1'b0;
	logic                 pwr_sw;
	psw_pkg::psw_wake_s   wake;
	psw_pkg::psw_os_cmd_s os_cmd;
	logic [4:0]           state;
	logic                 dev_pwr;
	logic                 wl_pwr;
	logic                 boot;
	logic                 intr;
	logic                 hit;
	psw_pkg::psw_state_e  tgt;
	psw_pkg::psw_wake_s   w;
	int                   errors       = 0;
	int                   total_checks = 0;
	int                   cyc          = 0;
	// ----------------------------------------------------------------
	// Clock, partner and design
	// ----------------------------------------------------------------
	always #25 core_clk_i = ~core_clk_i;
	psw_far_model far_u (.core_clk_i(core_clk_i), .wake_o(wake), .os_cmd_o(os_cmd),
		.pwr_sw_o(pwr_sw));
	psw_ctrl #(.PRESS_THR(THR)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.pwr_sw_i(pwr_sw), .intrusion_sw_i(intr_sw), .intrusion_clr_i(intr_clr),
		.wake_i(wake), .s5_lan_pme_en_i(s5_en), .os_cmd_i(os_cmd), .state_o(state),
		.dev_pwr_en_o(dev_pwr), .wake_logic_pwr_o(wl_pwr), .cold_boot_o(boot),
		.intrusion_o(intr));
	// ----------------------------------------------------------------
	// Expectations and checks
	// ----------------------------------------------------------------
	// Which sources may wake from a given sleep state
	function automatic logic woke(input logic [4:0] s, input psw_pkg::psw_wake_s v,
		input logic en);
		case (s)
			psw_pkg::PSW_S1, psw_pkg::PSW_S3: woke = |v;
			psw_pkg::PSW_S4: woke = v.lan | v.pme | v.rtc | v.pcie_wake;
			psw_pkg::PSW_S5: woke = v.rtc | v.pcie_wake | (en & (v.lan | v.pme));
			default: woke = 1'b0;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// State and its power outputs are judged together
	task automatic chk_st(input logic [4:0] e, input logic b);
		chk("state", e, state);
		chk("dev_pwr", {4'h0, e[0] | e[1]}, {4'h0, dev_pwr});
		chk("wake_pwr", 5'h01, {4'h0, wl_pwr});
		chk("cold_boot", {4'h0, b}, {4'h0, boot});
	endtask
	// Press, let the release edge land, then check
	task automatic press(input int n, input logic [4:0] e, input logic b);
		far_u.press(n);
		@(posedge core_clk_i);
		#1;
		chk_st(e, b);
	endtask
	task automatic end_sim();
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, well above the expected run length
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h4623));
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		chk_st(psw_pkg::PSW_S5, 1'b0);
		chk("intrusion", 5'h00, {4'h0, intr});
		press(THR, psw_pkg::PSW_S5, 1'b0);
		press(THR - 1, psw_pkg::PSW_S0, 1'b1);
		press(THR - 1, psw_pkg::PSW_S3, 1'b0);
		press(1, psw_pkg::PSW_S0, 1'b0);
		press(THR + 3, psw_pkg::PSW_S5, 1'b0);
		press(2, psw_pkg::PSW_S0, 1'b1);
		far_u.os_req(psw_pkg::PSW_S4);
		#1;
		chk_st(psw_pkg::PSW_S4, 1'b0);
		far_u.os_req(psw_pkg::PSW_S1);
		#1;
		chk_st(psw_pkg::PSW_S4, 1'b0);
		press(THR, psw_pkg::PSW_S5, 1'b0);
		press(3, psw_pkg::PSW_S0, 1'b1);
		// Frozen clock enable must swallow a request
		@(posedge core_clk_i) ce_i <= 1'b0;
		far_u.os_req(psw_pkg::PSW_S4);
		#1;
		chk_st(psw_pkg::PSW_S0, 1'b0);
		@(posedge core_clk_i) ce_i <= 1'b1;
		// Set beats clear while the cover is off
		intr_sw  <= 1'b1;
		intr_clr <= 1'b1;
		@(posedge core_clk_i) intr_sw <= 1'b0;
		#1;
		chk("intrusion", 5'h01, {4'h0, intr});
		@(posedge core_clk_i) intr_clr <= 1'b0;
		#1;
		chk("intrusion", 5'h00, {4'h0, intr});
		// Corner cases: a target that is no single sleep state, and wake while working
		far_u.os_req(psw_pkg::psw_state_e'(5'h03));
		#1;
		chk_st(psw_pkg::PSW_S0, 1'b0);
		far_u.wake(psw_pkg::psw_wake_s'(7'h7F));
		#1;
		chk_st(psw_pkg::PSW_S0, 1'b0);
		// Random sleep state, random wake sources, short press if still asleep
		repeat (40) begin
			tgt = psw_pkg::psw_state_e'(5'h02 << $urandom_range(0, 3));
			w   = psw_pkg::psw_wake_s'(7'($urandom_range(0, 127)));
			@(posedge core_clk_i) s5_en <= 1'($urandom_range(0, 1));
			far_u.os_req(tgt);
			#1;
			chk_st(tgt, 1'b0);
			hit = woke(tgt, w, s5_en);
			far_u.wake(w);
			#1;
			chk_st(hit ? psw_pkg::PSW_S0 : tgt, hit && tgt == psw_pkg::PSW_S5);
			if (!hit) begin
				press($urandom_range(1, THR - 1), psw_pkg::PSW_S0, tgt == psw_pkg::PSW_S5);
			end
		end
		end_sim();
	end
endmodule // psw_ctrl_tb

// File: dv/psw_far_model.sv
// Far-side model: front panel switch, wake sources and OS power software.
// Assumes it shares the controller clock and is steered by the bench tasks.
`timescale 1ns/1ns
module psw_far_model (
	// Clock
	input  wire logic            core_clk_i,
	// Toward the controller
	output psw_pkg::psw_wake_s   wake_o,
	output psw_pkg::psw_os_cmd_s os_cmd_o,
	output logic                 pwr_sw_o
);
	// ----------------------------------------------------------------
	// Stimulus tasks
	// ----------------------------------------------------------------
	// Idle levels at time zero
	initial begin
		pwr_sw_o = 1'b0;
		wake_o   = '0;
		os_cmd_o = '0;
	end
	// Switch held for n sampled cycles, then let go
	task automatic press(input int n);
		@(posedge core_clk_i) pwr_sw_o <= 1'b1;
		repeat (n) @(posedge core_clk_i);
		pwr_sw_o <= 1'b0;
	endtask
	// Wake lines pulse one cycle, so a stale level cannot wake twice
	task automatic wake(input psw_pkg::psw_wake_s w);
		@(posedge core_clk_i) wake_o <= w;
		@(posedge core_clk_i) wake_o <= '0;
	endtask
	// OS request, valid for exactly one cycle
	task automatic os_req(input psw_pkg::psw_state_e t);
		@(posedge core_clk_i) os_cmd_o <= {1'b1, t};
		@(posedge core_clk_i) os_cmd_o <= '0;
	endtask
endmodule // psw_far_model
